//--- rtl/rtcko_defines.svh
// Constants for the reload timer with clock output: Wishbone map, bit fields, resets.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
// What this block does
// RULE_01 - Two cascaded bytes form 16-bit count
// RULE_02 - Timer mode counts clock/12, counter counts pin
// RULE_03 - Counting only while run bit set
// RULE_04 - Capture, auto-reload, baud modes from select bits
// RULE_05 - Up/down mode: direction pin picks direction
// RULE_06 - Up overflow past FFFF sets overflow flag
// RULE_07 - Up overflow loads reload registers into count; code loads 0000 in capture mode
// RULE_08 - Down underflow when count equals reload value
// RULE_09 - Underflow sets flag, loads FFFF
// RULE_10 - Up/down wrap toggles external flag, no interrupt
// RULE_11 - Clock-out drives 50% square wave on pin
// RULE_12 - Clock-out advances low byte at clock/2
// RULE_13 - Clock-out reloads each overflow, no interrupt
// RULE_14 - Output frequency clock/(4*(65536-reload))
// RULE_15 - Software programs clock-out, run bit last
// RULE_16 - Baud and clock-out share one reload value
// RULE_17 - Counter mode counts falling pin edges
// RULE_18 - Flag set only when serial clocking off
// RULE_19 - Direction pin falling edge captures or reloads
// RULE_20 - Serial clocking forces reload, ignores capture
// RULE_21 - Clock-out toggles pin at each overflow
`ifndef RTCKO_DEFINES_SVH
`define RTCKO_DEFINES_SVH
`define RTCKO_ADR_CTRL 4'h0
`define RTCKO_ADR_MODE 4'h1
`define RTCKO_ADR_CNTL 4'h2
`define RTCKO_ADR_CNTH 4'h3
`define RTCKO_ADR_RLDL 4'h4
`define RTCKO_ADR_RLDH 4'h5
`define RTCKO_ADR_LSB 2
`define RTCKO_ADR_MSB 5
`define RTCKO_B_OVF 7
`define RTCKO_B_EXF 6
`define RTCKO_B_RX 5
`define RTCKO_B_TX 4
`define RTCKO_B_EXEN 3
`define RTCKO_B_RUN 2
`define RTCKO_B_CNT 1
`define RTCKO_B_CAP 0
`define RTCKO_B_CKOE 1
`define RTCKO_B_UDEN 0
`define RTCKO_PRESC_TIMER 4'hB
`define RTCKO_CNT_MAX 16'hFFFF
`define RTCKO_BYTE_ZERO 8'h00
`define RTCKO_WORD_ZERO 16'h0000
`define RTCKO_BUS_ZERO 32'h0000_0000
`endif

//--- rtl/rtcko_pkg.sv
// Types shared by the reload timer files.
// Assumes the defines header sits in the include path.
package rtcko_pkg;
   typedef struct packed
   {
      logic ovf;
      logic exf;
      logic rx_clk;
      logic tx_clk;
      logic exen;
      logic run;
      logic cnt_sel;
      logic cap_sel;
   } rtcko_ctrl_t;

   typedef struct packed
   {
      logic ck_oe;
      logic ud_en;
   } rtcko_mode_t;

   typedef enum logic [1:0]
   {
      RTCKO_CAPTURE = 2'h0,
      RTCKO_RELOAD = 2'h1,
      RTCKO_BAUD = 2'h3
   } rtcko_op_t;

   typedef struct packed
   {
      logic [31:0] dat;
      logic ack;
   } rtcko_wb_rsp_t;
endpackage : rtcko_pkg

//--- rtl/rtcko_pin_sync.sv
// Two-stage synchroniser with falling-edge detect for one pin.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/10ps
module rtcko_pin_sync
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic pin,
   output logic level,
   output logic fall
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // Edge detect looks only at the second stage
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         last_q <= 1'b1;
      end
      else if (ce)
      begin
         meta_q <= pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign fall = ce & last_q & ~sync_q;
endmodule : rtcko_pin_sync

//--- rtl/rtcko_timer.sv
// Reload timer with up/down counting and clock output, Wishbone register slave.
// Assumes a classic Wishbone master on clk_sys and pins asynchronous to it.
`timescale 1ns/10ps
`include "rtcko_defines.svh"
module rtcko_timer
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output rtcko_pkg::rtcko_wb_rsp_t wb_rsp_o,
   input wire logic timer_io_pin_i,
   output logic timer_io_pin_o,
   output logic timer_io_pin_oe,
   input wire logic direction_pin_i,
   output logic irq_req_o,
   output logic baud_tick_o
);
   import rtcko_pkg::*;

   logic rst_a_q;
   logic rst_n_q;
   rtcko_ctrl_t ctrl_q;
   rtcko_mode_t mode_q;
   logic [7:0] count_low_q;
   logic [7:0] count_high_q;
   logic [7:0] reload_low_q;
   logic [7:0] reload_high_q;
   logic [3:0] presc_q;
   logic half_q;
   logic ck_level_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic irq_q;
   logic baud_q;
   logic t_level;
   logic t_fall;
   logic d_level;
   logic d_fall;
   logic [15:0] count;
   logic [15:0] reload;
   logic serial_clk;
   logic clock_out;
   logic tick;
   logic count_up;
   logic wrap;
   logic [15:0] count_d;
   logic ext_event;
   logic cpu_wr;
   logic [3:0] reg_idx;
   logic wr_ctrl;
   rtcko_op_t op_mode;

   // Reset release through two flops; assert stays asynchronous
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_a_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_a_q <= 1'b1;
         rst_n_q <= rst_a_q;
      end
   end

   rtcko_pin_sync u_tpin
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n_q),
      .ce(clk_en),
      .pin(timer_io_pin_i),
      .level(t_level),
      .fall(t_fall)
   );

   rtcko_pin_sync u_dpin
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n_q),
      .ce(clk_en),
      .pin(direction_pin_i),
      .level(d_level),
      .fall(d_fall)
   );

   // Byte lane 0 write strobe for a register index
   function automatic logic wr_hit(input logic [3:0] idx);
      wr_hit = cpu_wr && (reg_idx == idx);
   endfunction : wr_hit

   assign count = {count_high_q, count_low_q}; // see RULE_01
   assign reload = {reload_high_q, reload_low_q}; // see RULE_16
   assign serial_clk = ctrl_q.rx_clk | ctrl_q.tx_clk;
   assign clock_out = mode_q.ck_oe & ~ctrl_q.cnt_sel;
   assign reg_idx = wb_adr_i[`RTCKO_ADR_MSB:`RTCKO_ADR_LSB];
   assign cpu_wr = clk_en & wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
   assign wr_ctrl = wr_hit(`RTCKO_ADR_CTRL);
   assign ext_event = ctrl_q.exen & ~serial_clk & d_fall; // see RULE_19

   // Mode decode; serial clocking overrides capture select
   always_comb
   begin
      if (serial_clk)
         op_mode = RTCKO_BAUD; // see RULE_20
      else if (ctrl_q.cap_sel)
         op_mode = RTCKO_CAPTURE; // see RULE_04
      else
         op_mode = RTCKO_RELOAD;
   end

   // Count tick: pin falling edge, clock/2 in clock-out or clock/12 otherwise
   always_comb
   begin
      if (!ctrl_q.run)
         tick = 1'b0; // see RULE_03
      else if (ctrl_q.cnt_sel)
         tick = t_fall; // see RULE_17
      else if (clock_out)
         tick = clk_en & half_q; // see RULE_12
      else
         tick = clk_en && (presc_q == `RTCKO_PRESC_TIMER); // see RULE_02
   end

   // Down counting only in reload mode with up/down enabled
   assign count_up = !(mode_q.ud_en && op_mode == RTCKO_RELOAD && !clock_out) || d_level; // see RULE_05

   // Next count and wrap detection
   always_comb
   begin
      count_d = count;
      wrap = 1'b0;
      if (tick)
      begin
         if (count_up)
         begin
            wrap = (count == `RTCKO_CNT_MAX); // see RULE_06
            count_d = wrap ? ((op_mode == RTCKO_CAPTURE) ? `RTCKO_WORD_ZERO : reload)
               : count + 16'h0001; // see RULE_07
         end
         else
         begin
            wrap = (count == reload); // see RULE_08
            count_d = wrap ? `RTCKO_CNT_MAX : count - 16'h0001; // see RULE_09
         end
      end
      else if (ext_event && op_mode == RTCKO_RELOAD && !mode_q.ud_en)
         count_d = reload; // see RULE_19
   end

   // Prescalers for the internal count sources
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         presc_q <= 4'h0;
         half_q <= 1'b0;
      end
      else if (clk_en)
      begin
         presc_q <= (presc_q == `RTCKO_PRESC_TIMER) ? 4'h0 : presc_q + 4'h1;
         half_q <= ~half_q;
      end
   end

   // Count bytes; software write takes priority over counting
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         count_low_q <= `RTCKO_BYTE_ZERO;
         count_high_q <= `RTCKO_BYTE_ZERO;
      end
      else if (clk_en)
      begin
         count_low_q <= wr_hit(`RTCKO_ADR_CNTL) ? wb_dat_i[7:0] : count_d[7:0];
         count_high_q <= wr_hit(`RTCKO_ADR_CNTH) ? wb_dat_i[7:0] : count_d[15:8];
      end
   end

   // Reload bytes; a capture event copies the count in
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         reload_low_q <= `RTCKO_BYTE_ZERO;
         reload_high_q <= `RTCKO_BYTE_ZERO;
      end
      else if (clk_en)
      begin
         if (ext_event && op_mode == RTCKO_CAPTURE)
         begin
            reload_low_q <= count_low_q;
            reload_high_q <= count_high_q;
         end
         else
         begin
            if (wr_hit(`RTCKO_ADR_RLDL))
               reload_low_q <= wb_dat_i[7:0];
            if (wr_hit(`RTCKO_ADR_RLDH))
               reload_high_q <= wb_dat_i[7:0];
         end
      end
   end

   // Control register; hardware sets win over a software clear
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         ctrl_q <= '0;
      else if (clk_en)
      begin
         if (wr_ctrl)
            ctrl_q <= rtcko_ctrl_t'(wb_dat_i[7:0]);
         if (wrap && !serial_clk && !clock_out)
            ctrl_q.ovf <= 1'b1; // see RULE_18
         if (wrap && mode_q.ud_en && !clock_out)
            ctrl_q.exf <= wr_ctrl ? ~wb_dat_i[`RTCKO_B_EXF] : ~ctrl_q.exf; // see RULE_10
         else if (ext_event && !mode_q.ud_en)
            ctrl_q.exf <= 1'b1;
      end
   end

   // Mode register: clock-out enable and up/down enable
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
         mode_q <= '0;
      else if (wr_hit(`RTCKO_ADR_MODE))
         mode_q <= rtcko_mode_t'(wb_dat_i[`RTCKO_B_CKOE:`RTCKO_B_UDEN]);
   end

   // Clock output: toggle per wrap gives 50% duty at clk/(4*(65536-reload))
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ck_level_q <= 1'b0;
         timer_io_pin_o <= 1'b0;
         timer_io_pin_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         if (wrap && clock_out)
            ck_level_q <= ~ck_level_q; // see RULE_21
         timer_io_pin_o <= ck_level_q; // see RULE_11
         timer_io_pin_oe <= clock_out; // see RULE_14
      end
   end

   // Interrupt request and serial baud tick; up/down toggling raises nothing
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         irq_q <= 1'b0;
         baud_q <= 1'b0;
      end
      else if (clk_en)
      begin
         irq_q <= ctrl_q.ovf | (ctrl_q.exf & ~mode_q.ud_en); // see RULE_13
         baud_q <= wrap & serial_clk; // see RULE_16
      end
   end

   assign irq_req_o = irq_q;
   assign baud_tick_o = baud_q;

   // Wishbone answer one cycle after strobe; unmapped reads give zero
   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ack_q <= 1'b0;
         rdat_q <= `RTCKO_BUS_ZERO;
      end
      else if (clk_en)
      begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
         case (reg_idx)
            `RTCKO_ADR_CTRL: rdat_q <= {24'h000000, ctrl_q};
            `RTCKO_ADR_MODE: rdat_q <= {30'h00000000, mode_q};
            `RTCKO_ADR_CNTL: rdat_q <= {24'h000000, count_low_q};
            `RTCKO_ADR_CNTH: rdat_q <= {24'h000000, count_high_q};
            `RTCKO_ADR_RLDL: rdat_q <= {24'h000000, reload_low_q};
            `RTCKO_ADR_RLDH: rdat_q <= {24'h000000, reload_high_q};
            default: rdat_q <= `RTCKO_BUS_ZERO;
         endcase
      end
   end

   assign wb_rsp_o.ack = ack_q;
   assign wb_rsp_o.dat = rdat_q;
endmodule : rtcko_timer

//--- testbench/rtcko_pins_model.sv
// Far-side pin model: an event source and a direction level.
// Assumes the bench calls its tasks; both pins idle high.
`timescale 1ns/10ps
module rtcko_pins_model
(
   input wire logic clk_sys,
   output logic ext_pin,
   output logic dir_pin
);
   // Idle high so only commanded pulses give falling edges
   initial
   begin
      ext_pin = 1'h1;
      dir_pin = 1'h1;
   end
   // Wide pulses mimic a slow source
   task automatic pulse(input int cnt, input int w);
      repeat (cnt)
      begin
         @(posedge clk_sys);
         ext_pin <= 1'h0;
         repeat (w) @(posedge clk_sys);
         ext_pin <= 1'h1;
         repeat (w) @(posedge clk_sys);
      end
   endtask : pulse
   // Level picks direction: high up, low down
   task automatic dir(input logic v);
      @(posedge clk_sys);
      dir_pin <= v;
   endtask : dir
endmodule : rtcko_pins_model

//--- testbench/rtcko_timer_chk.sv
// Port-level assertions for the reload timer.
// Assumes binding to rtcko_timer; one clock domain.
`timescale 1ns/10ps
module rtcko_timer_chk
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire rtcko_pkg::rtcko_wb_rsp_t wb_rsp_o,
   input wire logic timer_io_pin_o,
   input wire logic timer_io_pin_oe,
   input wire logic irq_req_o,
   input wire logic baud_tick_o
);
   import rtcko_pkg::*;
   logic [2:0] wr_q;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // Recent writes: only software changes mode bits or clears ovf; up/down wraps toggle exf
   always_ff @(posedge clk_sys or negedge reset_n)
      if (!reset_n)
         wr_q <= 3'h0;
      else
         wr_q <= {wr_q[1:0], wb_cyc_i & wb_stb_i & wb_we_i};
   // Bus answers
   a_ack_lat: assert property (wb_cyc_i && wb_stb_i && clk_en && !wb_rsp_o.ack
      |=> wb_rsp_o.ack) else $error("ack late");
   a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack held");
   a_ack_cause: assert property (wb_rsp_o.ack |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   // Pins and flags
   a_oe_cause: assert property ($changed(timer_io_pin_oe) |-> |wr_q)
      else $error("pin enable moved alone");
   a_ck_hold: assert property ($changed(timer_io_pin_o) && timer_io_pin_oe
      |=> $stable(timer_io_pin_o)) else $error("clock half too short");
   a_irq_clear: assert property ($fell(irq_req_o) |-> |wr_q)
      else $error("flag cleared by hardware");
   a_freeze_hold: assert property (!clk_en
      |=> $stable({irq_req_o, timer_io_pin_o, timer_io_pin_oe})) else $error("not frozen");
   a_baud_pulse: assert property (baud_tick_o && clk_en |=> !baud_tick_o)
      else $error("baud tick held");
   c_write: cover property (wb_rsp_o.ack && wb_we_i);
   c_clock_out: cover property ($changed(timer_io_pin_o) && timer_io_pin_oe);
   c_baud: cover property (baud_tick_o);
endmodule : rtcko_timer_chk

//--- testbench/tb_top.sv
// Self-checking bench: Wishbone tasks, pin model, timed pin checks.
// Assumes the pin model and checker are compiled first.
`timescale 1ns/10ps
module tb_top;
   import rtcko_pkg::*;
   logic clk_sys = 1'h0;
   logic reset_n = 1'h0;
   logic clk_en = 1'h1;
   logic cyc = 1'h0;
   logic stb = 1'h0;
   logic we = 1'h0;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] q;
   rtcko_wb_rsp_t rsp;
   logic pin_i, pin_o, pin_oe, ext_pin, dir_pin, irq, baud;
   int n_mismatch = 0;
   int checked = 0;
   int cyc_n = 0;
   int t0, t1, t2, a;
   // Clock, cycle count, pin wire
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc_n <= cyc_n + 1;
   assign pin_i = pin_oe ? pin_o : ext_pin;
   rtcko_timer u_rtcko_timer
   (
      .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
      .wb_rsp_o(rsp), .timer_io_pin_i(pin_i), .timer_io_pin_o(pin_o),
      .timer_io_pin_oe(pin_oe), .direction_pin_i(dir_pin), .irq_req_o(irq),
      .baud_tick_o(baud)
   );
   rtcko_pins_model u_rtcko_pins_model
   (.clk_sys(clk_sys), .ext_pin(ext_pin), .dir_pin(dir_pin));
   // One bus cycle; held until ack is sampled
   task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
      @(posedge clk_sys);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {26'h0, i, 2'h0};
      wdat <= {24'h0, d};
      // No fixed wait state assumed; only the watchdog ends a dead bus
      while (rsp.ack !== 1'h1) @(posedge clk_sys);
      q = rsp.dat;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask : bus
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [3:0] i, input logic [31:0] e);
      bus(1'h0, i, 8'h0);
      chk(q, e);
   endtask : rdc
   // Next pin toggle or baud tick; bounded so a dead output cannot hang
   task automatic wait_ev(input logic on_baud, output int t);
      logic v;
      @(posedge clk_sys);
      v = pin_o;
      repeat (300) if (on_baud ? baud !== 1'h1 : pin_o === v) @(posedge clk_sys);
      t = cyc_n;
   endtask : wait_ev
   task automatic stop_test;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      stop_test;
   end
   // Tests
   initial
   begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'h1;
      repeat (4) @(posedge clk_sys);
      bus(1'h1, 4'h7, 8'hFF);
      rdc(4'h7, 32'h0);
      rdc(4'h0, 32'h0);
      rdc(4'h1, 32'h0);
      $display("test reset done");
      bus(1'h1, 4'h2, 8'hFF);
      bus(1'h1, 4'h3, 8'h00);
      bus(1'h1, 4'h0, 8'h06);
      u_rtcko_pins_model.pulse(3, 2);
      repeat (4) @(posedge clk_sys);
      rdc(4'h2, 32'h02);
      rdc(4'h3, 32'h01);
      bus(1'h1, 4'h0, 8'h02);
      u_rtcko_pins_model.pulse(1, 5);
      repeat (4) @(posedge clk_sys);
      rdc(4'h2, 32'h02);
      $display("test counter done");
      bus(1'h1, 4'h1, 8'h01);
      bus(1'h1, 4'h4, 8'hF0);
      bus(1'h1, 4'h5, 8'hFF);
      bus(1'h1, 4'h2, 8'hFE);
      bus(1'h1, 4'h3, 8'hFF);
      bus(1'h1, 4'h0, 8'h06);
      u_rtcko_pins_model.pulse(3, 2);
      repeat (4) @(posedge clk_sys);
      rdc(4'h2, 32'hF1);
      rdc(4'h3, 32'hFF);
      rdc(4'h0, 32'hC6);
      chk({31'h0, irq}, 32'h1);
      bus(1'h1, 4'h0, 8'h46);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      u_rtcko_pins_model.dir(1'h0);
      bus(1'h1, 4'h2, 8'hF2);
      u_rtcko_pins_model.pulse(3, 2);
      repeat (4) @(posedge clk_sys);
      rdc(4'h2, 32'hFF);
      rdc(4'h3, 32'hFF);
      rdc(4'h0, 32'h86);
      $display("test up_down done");
      bus(1'h1, 4'h1, 8'h00);
      bus(1'h1, 4'h0, 8'h00);
      bus(1'h1, 4'h2, 8'h00);
      bus(1'h1, 4'h0, 8'h04);
      bus(1'h0, 4'h2, 8'h0);
      t0 = cyc_n;
      a = int'(q[7:0]);
      repeat (597) @(posedge clk_sys);
      bus(1'h0, 4'h2, 8'h0);
      a = int'(q[7:0]) - a;
      t1 = cyc_n - t0;
      chk({31'h0, a * 12 > t1 - 12 && a * 12 < t1 + 12}, 32'h1);
      $display("test timer done");
      bus(1'h1, 4'h0, 8'h00);
      bus(1'h1, 4'h1, 8'h02);
      bus(1'h1, 4'h4, 8'hF8);
      bus(1'h1, 4'h2, 8'hF8);
      bus(1'h1, 4'h0, 8'h04);
      chk({31'h0, pin_oe}, 32'h1);
      wait_ev(1'h0, t0);
      wait_ev(1'h0, t1);
      wait_ev(1'h0, t2);
      chk(t1 - t0, 32'h10);
      chk(t2 - t1, 32'h10);
      chk({31'h0, irq}, 32'h0);
      bus(1'h1, 4'h0, 8'h34);
      wait_ev(1'h1, t0);
      wait_ev(1'h1, t1);
      chk(t1 - t0, 32'h10);
      wait_ev(1'h0, t0);
      wait_ev(1'h0, t1);
      chk(t1 - t0, 32'h10);
      chk({31'h0, irq}, 32'h0);
      clk_en <= 1'h0;
      repeat (5) @(posedge clk_sys);
      clk_en <= 1'h1;
      repeat (4) @(posedge clk_sys);
      $display("test clock_out done");
      // Direction pin events: capture first, then reload, counter stopped
      u_rtcko_pins_model.dir(1'h1);
      bus(1'h1, 4'h1, 8'h00);
      bus(1'h1, 4'h0, 8'h09);
      bus(1'h1, 4'h2, 8'h34);
      bus(1'h1, 4'h3, 8'h12);
      u_rtcko_pins_model.dir(1'h0);
      repeat (4) @(posedge clk_sys);
      rdc(4'h4, 32'h34);
      rdc(4'h5, 32'h12);
      rdc(4'h0, 32'h49);
      chk({31'h0, irq}, 32'h1);
      u_rtcko_pins_model.dir(1'h1);
      bus(1'h1, 4'h0, 8'h08);
      bus(1'h1, 4'h2, 8'h00);
      bus(1'h1, 4'h3, 8'h00);
      u_rtcko_pins_model.dir(1'h0);
      repeat (4) @(posedge clk_sys);
      rdc(4'h2, 32'h34);
      rdc(4'h3, 32'h12);
      rdc(4'h0, 32'h48);
      $display("test event done");
      stop_test;
   end
endmodule : tb_top
bind rtcko_timer rtcko_timer_chk u_rtcko_timer_chk
(
   .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_rsp_o(wb_rsp_o),
   .timer_io_pin_o(timer_io_pin_o), .timer_io_pin_oe(timer_io_pin_oe),
   .irq_req_o(irq_req_o), .baud_tick_o(baud_tick_o)
);
